// ---- design/sdrpd_defines.svh ----
`ifndef SDRPD_DEFINES_SVH
`define SDRPD_DEFINES_SVH
// ----------------------------------------
// pin command codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDRPD_CMD_NOP 4'h7
`define SDRPD_CMD_ACT 4'h3
`define SDRPD_CMD_READ 4'h5
`define SDRPD_CMD_WRITE 4'h4
`define SDRPD_CMD_PRE 4'h2
`define SDRPD_CMD_REF 4'h1
// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define SDRPD_AP_BIT 8
`define SDRPD_ADDR_W 12
`define SDRPD_BANKS 4
`define SDRPD_CNT_W 8
// ----------------------------------------
// timing counts in sys_clk cycles
// ----------------------------------------
`define SDRPD_PDX_CYC 6
`define SDRPD_TRP_CYC 8
`define SDRPD_SELF_REFRESH_EXIT_PERIOD_CYC 20
`define SDRPD_WRITE_TO_READ_DELAY_CYC 2
`define SDRPD_RL_CYC 5
`define SDRPD_WL_CYC 3
`define SDRPD_BL 4
`endif

// ---- design/sdrpd_pkg.sv ----
`include "sdrpd_defines.svh"
package sdrpd_pkg;
    typedef logic [`SDRPD_CNT_W-1:0] sdrpd_cnt_type;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ACTIVATE = 4'h1,
        OP_READ = 4'h2,
        OP_WRITE = 4'h3,
        OP_PRECHARGE = 4'h4,
        OP_REFRESH = 4'h5,
        OP_PD_ENTER = 4'h6,
        OP_PD_EXIT = 4'h7,
        OP_SR_ENTER = 4'h8,
        OP_SR_EXIT = 4'h9
    } sdrpd_op_type;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_PD = 2'b01,
        MODE_SR = 2'b10
    } sdrpd_mode_type;

    typedef struct packed {
        sdrpd_op_type op;
        logic ap;
        logic [1:0] bank;
        logic [`SDRPD_ADDR_W-1:0] addr;
    } sdrpd_req_type;

    typedef struct packed {
        logic cke;
        logic [3:0] cmd;
        logic [1:0] ba;
        logic [`SDRPD_ADDR_W-1:0] addr;
    } sdrpd_pins_type;

    typedef struct packed {
        sdrpd_cnt_type cnt;
    } sdrpd_timer_state_type;

    typedef struct packed {
        sdrpd_mode_type mode;
        logic pend_valid;
        sdrpd_req_type pend;
        logic [`SDRPD_BANKS-1:0] bank_open;
        sdrpd_cnt_type burst_cnt;
        sdrpd_cnt_type wtr_cnt;
        sdrpd_cnt_type exit_cnt;
        sdrpd_pins_type pins;
        logic ready;
        logic done;
        logic refused;
    } sdrpd_state_type;
endpackage : sdrpd_pkg

// ---- design/sdrpd_timer.sv ----
`timescale 1ns/10ps
`include "sdrpd_defines.svh"
module sdrpd_timer (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load,
    input sdrpd_pkg::sdrpd_cnt_type load_val,
    output logic busy
);
    import sdrpd_pkg::*;

    sdrpd_timer_state_type q;
    sdrpd_timer_state_type n;

    // reload or count down to zero
    always_comb begin
        n = q;
        if (load) begin
            n.cnt = load_val;
        end else if (q.cnt != '0) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign busy = (q.cnt != '0);
endmodule : sdrpd_timer

// ---- design/sdrpd_ctrl.sv ----
// Behaviour
// - auto-precharge bit picks one or all banks; bank bits name the bank.
// - no activate to a bank before the precharge period has elapsed.
// - precharged bank is idle; activate it before any read or write.
// - keep clock enable high from read or write until burst completes.
// - read done after postamble; write done half burst after write postamble.
// - prefer self-refresh over long power-down because of refresh needs.
// - during power-down hold clock enable low and clock running.
// - power-down exit on clock enable high, together with a no-operation.
// - wait six cycles after power-down exit before any executable command.
// - only no-operations until the self-refresh exit period has passed.
// - never issue an unlisted clock enable, state and command combination.
// - consecutive writes may go to any bank.
// - read waits write-to-read delay after the last write data pair.
`timescale 1ns/10ps
`include "sdrpd_defines.svh"
module sdrpd_ctrl #(
    parameter int TRP_CYC = `SDRPD_TRP_CYC,
    parameter int SELF_REFRESH_EXIT_PERIOD_CYC = `SDRPD_SELF_REFRESH_EXIT_PERIOD_CYC,
    parameter int PDX_CYC = `SDRPD_PDX_CYC,
    parameter int WRITE_TO_READ_DELAY_CYC = `SDRPD_WRITE_TO_READ_DELAY_CYC,
    parameter int RL_CYC = `SDRPD_RL_CYC,
    parameter int WL_CYC = `SDRPD_WL_CYC,
    parameter int BL = `SDRPD_BL
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input sdrpd_pkg::sdrpd_req_type req,
    output logic req_ready,
    output logic rsp_done,
    output logic rsp_refused,
    output sdrpd_pkg::sdrpd_mode_type cur_mode,
    output sdrpd_pkg::sdrpd_pins_type mem
);
    import sdrpd_pkg::*;

    // ----------------------------------------
    // timing values
    // ----------------------------------------
    localparam int RD_DONE_I = RL_CYC + BL / 2 + 1;
    localparam int WR_DONE_I = WL_CYC + BL / 2 + 1 + BL / 2;
    localparam int WTR_I = WL_CYC + BL / 2 + WRITE_TO_READ_DELAY_CYC;
    localparam sdrpd_cnt_type TRP_V = sdrpd_cnt_type'(TRP_CYC);
    localparam sdrpd_cnt_type SELF_REFRESH_EXIT_PERIOD_V = sdrpd_cnt_type'(SELF_REFRESH_EXIT_PERIOD_CYC);
    localparam sdrpd_cnt_type PDX_V = sdrpd_cnt_type'(PDX_CYC);
    localparam sdrpd_cnt_type RD_DONE_V = sdrpd_cnt_type'(RD_DONE_I);
    localparam sdrpd_cnt_type WR_DONE_V = sdrpd_cnt_type'(WR_DONE_I);
    localparam sdrpd_cnt_type WTR_V = sdrpd_cnt_type'(WTR_I);
    localparam sdrpd_cnt_type RD_AP_V = sdrpd_cnt_type'(RD_DONE_I + TRP_CYC);
    localparam sdrpd_cnt_type WR_AP_V = sdrpd_cnt_type'(WR_DONE_I + TRP_CYC);
    localparam sdrpd_pins_type PINS_RST = '{cke: 1'b1, cmd: `SDRPD_CMD_NOP, ba: 2'h0, addr: '0};

    sdrpd_state_type q;
    sdrpd_state_type n;
    logic [`SDRPD_BANKS-1:0] trp_load;
    logic [`SDRPD_BANKS-1:0] trp_busy;
    sdrpd_cnt_type trp_val;
    logic finish;
    logic refuse;
    logic hold;

    // ----------------------------------------
    // per-bank precharge period timers
    // ----------------------------------------
    for (genvar b = 0; b < `SDRPD_BANKS; b++) begin : g_bank
        sdrpd_timer u_trp (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .load(trp_load[b]),
            .load_val(trp_val),
            .busy(trp_busy[b])
        );
    end

    // ----------------------------------------
    // command sequencing
    // ----------------------------------------
    // one pending request, issued once its timing is met
    always_comb begin
        n = q;
        trp_load = '0;
        trp_val = TRP_V;
        finish = 1'b0;
        refuse = 1'b0;
        hold = (q.exit_cnt != '0) || (q.mode != MODE_RUN);
        n.done = 1'b0;
        n.refused = 1'b0;
        n.pins.cmd = `SDRPD_CMD_NOP;
        n.pins.ba = 2'h0;
        n.pins.addr = '0;
        if (q.burst_cnt != '0) n.burst_cnt = q.burst_cnt - 1'b1;
        if (q.wtr_cnt != '0) n.wtr_cnt = q.wtr_cnt - 1'b1;
        if (q.exit_cnt != '0) n.exit_cnt = q.exit_cnt - 1'b1;
        if (q.pend_valid) begin
            case (q.mode)
                MODE_RUN: begin
                    case (q.pend.op)
                        OP_NOP: begin
                            finish = 1'b1;
                        end
                        OP_ACTIVATE: begin
                            if (q.bank_open[q.pend.bank]) begin
                                refuse = 1'b1;
                            end else if (!hold && !trp_busy[q.pend.bank]) begin
                                n.pins.cmd = `SDRPD_CMD_ACT;
                                n.pins.ba = q.pend.bank;
                                n.pins.addr = q.pend.addr;
                                n.bank_open[q.pend.bank] = 1'b1;
                                finish = 1'b1;
                            end
                        end
                        OP_READ, OP_WRITE: begin
                            if (!q.bank_open[q.pend.bank]) begin
                                refuse = 1'b1;
                            end else if (!hold && (q.pend.op == OP_WRITE || q.wtr_cnt == '0)) begin
                                n.pins.cmd = (q.pend.op == OP_WRITE) ? `SDRPD_CMD_WRITE : `SDRPD_CMD_READ;
                                n.pins.ba = q.pend.bank;
                                n.pins.addr = q.pend.addr;
                                n.pins.addr[`SDRPD_AP_BIT] = q.pend.ap;
                                if (q.pend.op == OP_WRITE) begin
                                    n.burst_cnt = WR_DONE_V;
                                    n.wtr_cnt = WTR_V;
                                end else if (q.burst_cnt < RD_DONE_V) begin
                                    n.burst_cnt = RD_DONE_V;
                                end
                                if (q.pend.ap) begin
                                    n.bank_open[q.pend.bank] = 1'b0;
                                    trp_load[q.pend.bank] = 1'b1;
                                    trp_val = (q.pend.op == OP_WRITE) ? WR_AP_V : RD_AP_V;
                                end
                                finish = 1'b1;
                            end
                        end
                        OP_PRECHARGE: begin
                            if (!hold && q.burst_cnt == '0) begin
                                n.pins.cmd = `SDRPD_CMD_PRE;
                                n.pins.addr[`SDRPD_AP_BIT] = q.pend.ap;
                                if (q.pend.ap) begin
                                    n.bank_open = '0;
                                    trp_load = '1;
                                end else begin
                                    n.pins.ba = q.pend.bank;
                                    n.bank_open[q.pend.bank] = 1'b0;
                                    trp_load[q.pend.bank] = 1'b1;
                                end
                                finish = 1'b1;
                            end
                        end
                        OP_REFRESH, OP_SR_ENTER: begin
                            if (q.bank_open != '0) begin
                                refuse = 1'b1;
                            end else if (!hold && q.burst_cnt == '0 && trp_busy == '0) begin
                                n.pins.cmd = `SDRPD_CMD_REF;
                                if (q.pend.op == OP_SR_ENTER) begin
                                    n.pins.cke = 1'b0;
                                    n.mode = MODE_SR;
                                end
                                finish = 1'b1;
                            end
                        end
                        OP_PD_ENTER: begin
                            if (!hold && q.burst_cnt == '0) begin
                                n.pins.cke = 1'b0;
                                n.mode = MODE_PD;
                                finish = 1'b1;
                            end
                        end
                        default: begin
                            refuse = 1'b1;
                        end
                    endcase
                end
                MODE_PD, MODE_SR: begin
                    // clock enable stays low: n keeps q.pins.cke until an exit
                    if (q.pend.op == OP_NOP) begin
                        finish = 1'b1;
                    end else if ((q.mode == MODE_PD && q.pend.op == OP_PD_EXIT) ||
                                 (q.mode == MODE_SR && q.pend.op == OP_SR_EXIT)) begin
                        n.pins.cke = 1'b1;
                        n.mode = MODE_RUN;
                        n.exit_cnt = (q.mode == MODE_PD) ? PDX_V : SELF_REFRESH_EXIT_PERIOD_V;
                        finish = 1'b1;
                    end else begin
                        refuse = 1'b1;
                    end
                end
                default: begin
                    refuse = 1'b1;
                end
            endcase
        end
        if (finish || refuse) begin
            n.pend_valid = 1'b0;
            n.done = finish;
            n.refused = refuse;
        end
        if (req_valid && q.ready) begin
            n.pend = req;
            n.pend_valid = 1'b1;
        end
        n.ready = !n.pend_valid;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.pins <= PINS_RST;
            q.ready <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign mem = q.pins;
    assign cur_mode = q.mode;
    assign req_ready = q.ready;
    assign rsp_done = q.done;
    assign rsp_refused = q.refused;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence pd_left_s;
        $rose(mem.cke) && $past(q.mode) == MODE_PD;
    endsequence

    sequence nop_six_s;
        (mem.cmd == `SDRPD_CMD_NOP) [*6];
    endsequence

    pd_cke_low_a: assert property (q.mode != MODE_RUN |-> !mem.cke)
        else $error("clock enable high while powered down");
    pd_exit_nop_a: assert property ($rose(mem.cke) |-> mem.cmd == `SDRPD_CMD_NOP)
        else $error("power-down exit without no-operation");
    pd_exit_wait_a: assert property (pd_left_s |-> nop_six_s)
        else $error("command too soon after power-down exit");
    exit_period_a: assert property (q.exit_cnt != '0 |-> mem.cmd == `SDRPD_CMD_NOP)
        else $error("command during exit period");
    rw_open_bank_a: assert property ((mem.cmd == `SDRPD_CMD_READ || mem.cmd == `SDRPD_CMD_WRITE)
        |-> ($past(q.bank_open) & (4'h1 << mem.ba)) != 4'h0)
        else $error("read or write to idle bank");
    act_trp_a: assert property (mem.cmd == `SDRPD_CMD_ACT
        |-> ($past(trp_busy) & (4'h1 << mem.ba)) == 4'h0)
        else $error("activate inside precharge period");
    burst_cke_a: assert property ($fell(mem.cke) |-> $past(q.burst_cnt) == '0)
        else $error("clock enable dropped during burst");
    all_precharge_a: assert property (mem.cmd == `SDRPD_CMD_PRE && mem.addr[`SDRPD_AP_BIT]
        |-> q.bank_open == '0 && trp_busy == '1)
        else $error("all-bank precharge left a bank open");
    wtr_gap_a: assert property (mem.cmd == `SDRPD_CMD_WRITE
        |=> (mem.cmd != `SDRPD_CMD_READ) [*6])
        else $error("read too soon after write");
    sr_entry_a: assert property ($fell(mem.cke) && mem.cmd == `SDRPD_CMD_REF
        |-> $past(q.bank_open) == '0 && q.mode == MODE_SR)
        else $error("self-refresh entered with open bank");
    pd_quiet_a: assert property (q.mode != MODE_RUN && $past(q.mode) != MODE_RUN
        |-> mem.cmd == `SDRPD_CMD_NOP)
        else $error("command while powered down");
endmodule : sdrpd_ctrl

// ---- sim/sdrpd_dev_model.sv ----
`timescale 1ns/10ps
`include "sdrpd_defines.svh"
module sdrpd_dev_model #(
    parameter int TRP_CYC = 8,
    parameter int SELF_REFRESH_EXIT_PERIOD_CYC = 20,
    parameter int PDX_CYC = 6
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input sdrpd_pkg::sdrpd_pins_type mem,
    output logic [3:0] bank_open,
    output sdrpd_pkg::sdrpd_mode_type dev_mode,
    output logic act_pd,
    output int viol
);
    import sdrpd_pkg::*;
    logic cke_prev;
    int gap;
    int precharge_period [4];
    // ----------------------------------------
    // device state, counts illegal commands
    // ----------------------------------------
    // behavioural, read by the bench off the rising edge only
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bank_open = 4'h0;
            dev_mode = MODE_RUN;
            act_pd = 1'b0;
            viol = 0;
            cke_prev = 1'b1;
            gap = 0;
            foreach (precharge_period[i]) precharge_period[i] = 0;
        end else begin
            foreach (precharge_period[i]) if (precharge_period[i] > 0) precharge_period[i]--;
            if (gap > 0) gap--;
            if (!cke_prev && !mem.cke) begin
                // inputs other than clock enable ignored while down
                dev_mode = dev_mode;
            end else if (!cke_prev && mem.cke) begin
                if (mem.cmd != `SDRPD_CMD_NOP) viol++;
                gap = (dev_mode == MODE_SR) ? SELF_REFRESH_EXIT_PERIOD_CYC : PDX_CYC;
                dev_mode = MODE_RUN;
            end else if (cke_prev && !mem.cke) begin
                act_pd = |bank_open;
                if (mem.cmd == `SDRPD_CMD_REF && bank_open == 4'h0) dev_mode = MODE_SR;
                else if (mem.cmd == `SDRPD_CMD_NOP) dev_mode = MODE_PD;
                else viol++;
            end else if (mem.cmd != `SDRPD_CMD_NOP) begin
                if (gap > 0) viol++;
                case (mem.cmd)
                    `SDRPD_CMD_ACT: begin
                        if (bank_open[mem.ba] || precharge_period[mem.ba] > 0) viol++;
                        bank_open[mem.ba] = 1'b1;
                    end
                    `SDRPD_CMD_READ, `SDRPD_CMD_WRITE: begin
                        if (!bank_open[mem.ba]) viol++;
                        if (mem.addr[`SDRPD_AP_BIT]) bank_open[mem.ba] = 1'b0;
                    end
                    `SDRPD_CMD_PRE: begin
                        for (int b = 0; b < 4; b++) begin
                            if (mem.addr[`SDRPD_AP_BIT] || b == mem.ba) begin
                                bank_open[b] = 1'b0;
                                precharge_period[b] = TRP_CYC;
                            end
                        end
                    end
                    `SDRPD_CMD_REF: if (bank_open != 4'h0) viol++;
                    default: viol++;
                endcase
            end
            cke_prev = mem.cke;
        end
    end
endmodule : sdrpd_dev_model

// ---- sim/sdrpd_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`include "sdrpd_defines.svh"
module sdrpd_ctrl_tb_top;
    import sdrpd_pkg::*;
    localparam int PRECHARGE_PERIOD = 2;
    localparam int SELF_REFRESH_EXIT_PERIOD = 4;
    localparam int PDX = `SDRPD_PDX_CYC;
    localparam int WTR = `SDRPD_WL_CYC + `SDRPD_BL / 2 + `SDRPD_WRITE_TO_READ_DELAY_CYC;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    sdrpd_req_type req = '0;
    logic req_ready, rsp_done, rsp_refused, act_pd;
    sdrpd_mode_type cur_mode, dev_mode;
    sdrpd_pins_type mem, got;
    logic [3:0] bank_open;
    int viol, t_done;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    // ----------------------------------------
    // clock, cycle count, instances
    // ----------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    sdrpd_ctrl #(.TRP_CYC(PRECHARGE_PERIOD), .SELF_REFRESH_EXIT_PERIOD_CYC(SELF_REFRESH_EXIT_PERIOD)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_done(rsp_done),
        .rsp_refused(rsp_refused), .cur_mode(cur_mode), .mem(mem));
    sdrpd_dev_model #(.TRP_CYC(PRECHARGE_PERIOD), .SELF_REFRESH_EXIT_PERIOD_CYC(SELF_REFRESH_EXIT_PERIOD), .PDX_CYC(PDX)) i_dev (.sys_clk(sys_clk),
        .rstn(rstn), .mem(mem), .bank_open(bank_open), .dev_mode(dev_mode), .act_pd(act_pd), .viol(viol));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic c, input string m);
        checks++;
        if (c !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // one request, waits for its answer, then lets the model see the pins
    task automatic issue(input sdrpd_op_type op, input logic ap, input logic [1:0] bk, input logic exp_ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{op: op, ap: ap, bank: bk, addr: 12'h0A5};
        @(negedge sys_clk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        chk(req_ready === 1'b0, "ready during pending request");
        do begin
            @(negedge sys_clk);
            n++;
        end while (rsp_done !== 1'b1 && rsp_refused !== 1'b1 && n < 200);
        if (n >= 200) begin
            err_count++;
            report_and_stop();
        end
        got = mem;
        t_done = cyc;
        chk(rsp_done === exp_ok && rsp_refused === !exp_ok && req_ready === 1'b1, "answer kind");
        if (!exp_ok) chk(got.cmd === `SDRPD_CMD_NOP, "pins moved on refusal");
        @(negedge sys_clk);
    endtask : issue
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_rw;
        int tw;
        issue(OP_READ, 1'b0, 2'h1, 1'b0);
        issue(OP_ACTIVATE, 1'b0, 2'h1, 1'b1);
        chk(got.cmd === `SDRPD_CMD_ACT && got.ba === 2'h1 && got.addr === 12'h0A5, "activate pins");
        issue(OP_ACTIVATE, 1'b0, 2'h1, 1'b0);
        issue(OP_ACTIVATE, 1'b0, 2'h2, 1'b1);
        issue(OP_WRITE, 1'b0, 2'h2, 1'b1);
        issue(OP_WRITE, 1'b0, 2'h1, 1'b1);
        chk(got.cmd === `SDRPD_CMD_WRITE && got.addr[`SDRPD_AP_BIT] === 1'b0, "write pins");
        tw = t_done;
        issue(OP_READ, 1'b0, 2'h1, 1'b1);
        chk(t_done - tw >= WTR && bank_open === 4'h6, "write to read");
    endtask : t_rw
    task automatic t_pre;
        issue(OP_REFRESH, 1'b0, 2'h0, 1'b0);
        issue(OP_PRECHARGE, 1'b0, 2'h1, 1'b1);
        chk(got.cmd === `SDRPD_CMD_PRE && got.ba === 2'h1 && got.addr[8] === 1'b0, "bank precharge");
        chk(bank_open === 4'h4, "one bank closed");
        issue(OP_ACTIVATE, 1'b0, 2'h1, 1'b1);
        issue(OP_PRECHARGE, 1'b1, 2'h3, 1'b1);
        chk(got.ba === 2'h0 && got.addr[8] === 1'b1 && bank_open === 4'h0, "all precharge");
    endtask : t_pre
    task automatic t_pd;
        int tx;
        issue(OP_ACTIVATE, 1'b0, 2'h0, 1'b1);
        issue(OP_WRITE, 1'b0, 2'h0, 1'b1);
        tx = t_done;
        issue(OP_PD_ENTER, 1'b0, 2'h0, 1'b1);
        chk(t_done - tx >= `SDRPD_WL_CYC + `SDRPD_BL, "pd entry inside burst");
        chk(got.cke === 1'b0 && got.cmd === `SDRPD_CMD_NOP && cur_mode === MODE_PD, "pd entry");
        chk(dev_mode === MODE_PD && act_pd === 1'b1, "active pd");
        issue(OP_PRECHARGE, 1'b1, 2'h0, 1'b0);
        chk(mem.cke === 1'b0 && dev_mode === MODE_PD, "cke held low");
        issue(OP_PD_EXIT, 1'b0, 2'h0, 1'b1);
        chk(got.cke === 1'b1 && got.cmd === `SDRPD_CMD_NOP && dev_mode === MODE_RUN, "pd exit");
        tx = t_done;
        issue(OP_PRECHARGE, 1'b1, 2'h0, 1'b1);
        chk(t_done - tx >= PDX, "pd exit wait");
        issue(OP_PD_ENTER, 1'b0, 2'h0, 1'b1);
        chk(act_pd === 1'b0, "precharge pd");
        issue(OP_PD_EXIT, 1'b0, 2'h0, 1'b1);
    endtask : t_pd
    task automatic t_sr;
        int tx;
        issue(OP_SR_ENTER, 1'b0, 2'h0, 1'b1);
        chk(got.cke === 1'b0 && got.cmd === `SDRPD_CMD_REF && cur_mode === MODE_SR, "sr entry");
        chk(dev_mode === MODE_SR, "model in sr");
        issue(OP_PD_EXIT, 1'b0, 2'h0, 1'b0);
        issue(OP_SR_EXIT, 1'b0, 2'h0, 1'b1);
        chk(got.cke === 1'b1 && got.cmd === `SDRPD_CMD_NOP && cur_mode === MODE_RUN, "sr exit");
        tx = t_done;
        issue(OP_ACTIVATE, 1'b0, 2'h3, 1'b1);
        chk(t_done - tx >= SELF_REFRESH_EXIT_PERIOD, "sr exit wait");
        issue(OP_READ, 1'b1, 2'h3, 1'b1);
        chk(got.cmd === `SDRPD_CMD_READ && got.addr[`SDRPD_AP_BIT] === 1'b1 && bank_open === 4'h0, "ap read");
        tx = t_done;
        issue(OP_REFRESH, 1'b0, 2'h0, 1'b1);
        chk(got.cmd === `SDRPD_CMD_REF && got.cke === 1'b1, "refresh pins");
        chk(t_done - tx >= `SDRPD_RL_CYC + `SDRPD_BL / 2 + PRECHARGE_PERIOD, "refresh after auto-precharge");
        issue(OP_NOP, 1'b0, 2'h0, 1'b1);
        chk(got.cmd === `SDRPD_CMD_NOP && got.cke === 1'b1, "no-operation request");
    endtask : t_sr
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_rw();
        t_pre();
        t_pd();
        t_sr();
        chk(viol === 0, "device model saw an illegal command");
        report_and_stop();
    end
endmodule : sdrpd_ctrl_tb_top
